//--- verilog/hdu_uart.sv
// half-duplex nine-bit serial port with avalon-mm register slave
// Contract
// - frame is start, nine data bits, stop: eleven bits, half-duplex only
// - starting a transmission aborts any reception in progress
// - eight states per bit, bit decided by two-of-three vote of samples
// - baud code selects division 6656 down to 208, code 111 reserved
// - data write sends start zero, eight bits lsb first, ninth bit, stop one
// - serial output line carries the transmitted data inverted
// - output select gives pin to transmitter only while sending, else port value
// - after stop bit transmitter-empty flag sets and may request interrupt
// - transmitter-empty clears on zero write or data write, one write sets it
// - when not sending, receiver hunts falling edge, waits one bit, assembles
// - received ninth bit overwrites the ninth-bit field, else it is kept
// - after nine bits wait a stop bit, then move character to buffer
// - receiver-ready sets on buffer load, interrupts if enabled, writable
// - writing enables never changes pending flags, enables only gate them
// - data read returns receive buffer, data write loads transmit shifter
// - baud select changes act immediately, avoid changing mid-character
// - port runs on its internal clock regardless of processor wait mode
`timescale 1ns/10ps
module hdu_uart (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [9:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic serial_in_pin,
    input wire logic port_out_value,
    output logic serial_out_pin,
    output logic transmitter_output_select,
    output logic uart_irq
);
    logic bus_ack, next_bus_ack;
    logic [31:0] next_readdata;
    logic data_wr, ctrl_wr;
    logic in_s1, in_s2, in_s3, rx_level, next_rx_level, rx_fall;
    logic [9:0] presc, next_presc, presc_limit;
    logic baud_ok, tick;
    logic [13:0] div_sel;
    hdu_pkg::hdu_tx_state_t tx_state, next_tx_state;
    logic [10:0] tx_shift, next_tx_shift;
    logic [3:0] tx_pos, next_tx_pos;
    logic [2:0] tx_phase, next_tx_phase;
    logic tx_done, next_pin;
    hdu_pkg::hdu_rx_state_t rx_state, next_rx_state;
    logic [8:0] rx_shift, next_rx_shift;
    logic [3:0] rx_pos, next_rx_pos;
    logic [2:0] rx_phase, next_rx_phase;
    logic [2:0] votes, next_votes;
    logic rx_done, ninth_load, vote_bit;
    logic [7:0] rx_buffer, next_rx_buffer;
    logic receiver_ready_flag, transmitter_empty_flag, receive_irq_enable, transmit_irq_enable, ninth_bit;
    logic next_receiver_ready_flag, next_transmitter_empty_flag, next_receive_irq_enable, next_transmit_irq_enable, next_ninth_bit;
    logic [2:0] baud_select, next_baud_select;

    // avalon slave: one wait cycle, write and read take effect on the ack edge
    assign avs_waitrequest = (avs_read | avs_write) & ~bus_ack;
    assign data_wr = avs_write & bus_ack & avs_byteenable[0]
        & (avs_address == hdu_pkg::HDU_DATA_ADDR);
    assign ctrl_wr = avs_write & bus_ack & avs_byteenable[0]
        & (avs_address == hdu_pkg::HDU_CTRL_ADDR);

    always_comb begin
        next_bus_ack = (avs_read | avs_write) & ~bus_ack;
        next_readdata = avs_readdata;
        if (avs_read & ~bus_ack) begin
            // unmapped addresses read as zero
            next_readdata = 32'h0000_0000;
            if (avs_address == hdu_pkg::HDU_DATA_ADDR) begin
                next_readdata[7:0] = rx_buffer;
            end else if (avs_address == hdu_pkg::HDU_CTRL_ADDR) begin
                next_readdata[7:0] = {receiver_ready_flag, transmitter_empty_flag, receive_irq_enable, transmit_irq_enable, baud_select, ninth_bit};
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            bus_ack <= 1'b0;
            avs_readdata <= 32'h0000_0000;
        end else begin
            bus_ack <= next_bus_ack;
            avs_readdata <= next_readdata;
        end
    end

    // pin synchroniser: level changes once second and third stage agree
    assign rx_fall = rx_level & (in_s2 == in_s3) & ~in_s3;

    always_comb begin
        next_rx_level = (in_s2 == in_s3) ? in_s3 : rx_level;
    end

    // clock divider, one tick per state, eight states per bit
    always_comb begin
        baud_ok = 1'b1;
        case (baud_select)
            3'h0: div_sel = hdu_pkg::HDU_DIV0;
            3'h1: div_sel = hdu_pkg::HDU_DIV1;
            3'h2: div_sel = hdu_pkg::HDU_DIV2;
            3'h3: div_sel = hdu_pkg::HDU_DIV3;
            3'h4: div_sel = hdu_pkg::HDU_DIV4;
            3'h5: div_sel = hdu_pkg::HDU_DIV5;
            3'h6: div_sel = hdu_pkg::HDU_DIV6;
            default: begin
                div_sel = hdu_pkg::HDU_DIV0;
                baud_ok = 1'b0;
            end
        endcase
        presc_limit = 10'(div_sel >> hdu_pkg::HDU_STATE_SHIFT) - 10'h001;
        // compare against the live code so a new baud acts at once
        tick = baud_ok & (presc >= presc_limit);
        next_presc = tick ? 10'h000 : presc + 10'h001;
        if (!baud_ok) begin
            next_presc = 10'h000;
        end
        // restart at a frame start; line edges while sending must not upset tx bit timing
        if (data_wr | (rx_fall & (rx_state == hdu_pkg::HDU_RX_HUNT)
                & (tx_state == hdu_pkg::HDU_TX_IDLE))) begin
            next_presc = 10'h000;
        end
    end

    // the block keeps running on sys_clk whatever the core is doing
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            in_s1 <= 1'b1;
            in_s2 <= 1'b1;
            in_s3 <= 1'b1;
            rx_level <= 1'b1;
            presc <= 10'h000;
        end else begin
            in_s1 <= serial_in_pin;
            in_s2 <= in_s1;
            in_s3 <= in_s2;
            rx_level <= next_rx_level;
            presc <= next_presc;
        end
    end

    // transmitter: eleven-bit shifter, line bit is shifter lsb
    always_comb begin
        next_tx_state = tx_state;
        next_tx_shift = tx_shift;
        next_tx_pos = tx_pos;
        next_tx_phase = tx_phase;
        tx_done = 1'b0;
        case (tx_state)
            hdu_pkg::HDU_TX_IDLE: begin
            end
            hdu_pkg::HDU_TX_SEND: begin
                if (tick) begin
                    next_tx_phase = tx_phase + 3'h1;
                    if (tx_phase == hdu_pkg::HDU_LAST_PHASE) begin
                        next_tx_shift = {1'b1, tx_shift[10:1]};
                        next_tx_pos = tx_pos + 4'h1;
                        if (tx_pos == hdu_pkg::HDU_STOP_POS) begin
                            next_tx_state = hdu_pkg::HDU_TX_IDLE;
                            tx_done = 1'b1;
                        end
                    end
                end
            end
            default: next_tx_state = hdu_pkg::HDU_TX_IDLE;
        endcase
        // a new data write always restarts the frame, even mid-character
        if (data_wr) begin
            next_tx_state = hdu_pkg::HDU_TX_SEND;
            next_tx_shift = {1'b1, ninth_bit, avs_writedata[7:0], 1'b0};
            next_tx_pos = 4'h0;
            next_tx_phase = 3'h0;
            tx_done = 1'b0;
        end
        // inverted data while sending, port value otherwise
        if (tx_state == hdu_pkg::HDU_TX_SEND) begin
            next_pin = ~tx_shift[0];
        end else begin
            next_pin = port_out_value;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            tx_state <= hdu_pkg::HDU_TX_IDLE;
            tx_shift <= 11'h7ff;
            tx_pos <= 4'h0;
            tx_phase <= 3'h0;
            serial_out_pin <= 1'b0;
        end else begin
            tx_state <= next_tx_state;
            tx_shift <= next_tx_shift;
            tx_pos <= next_tx_pos;
            tx_phase <= next_tx_phase;
            serial_out_pin <= next_pin;
        end
    end

    assign transmitter_output_select = (tx_state == hdu_pkg::HDU_TX_SEND);

    // receiver: vote over phases three to five, decide at phase seven; the stop bit
    // ends at its last sample so a start edge right behind it still finds the hunt
    assign vote_bit = (votes[0] & votes[1]) | (votes[0] & votes[2]) | (votes[1] & votes[2]);

    always_comb begin
        next_rx_state = rx_state;
        next_rx_shift = rx_shift;
        next_rx_pos = rx_pos;
        next_rx_phase = rx_phase;
        next_votes = votes;
        next_rx_buffer = rx_buffer;
        rx_done = 1'b0;
        ninth_load = 1'b0;
        case (rx_state)
            hdu_pkg::HDU_RX_HUNT: begin
                if (rx_fall & (tx_state == hdu_pkg::HDU_TX_IDLE)) begin
                    next_rx_state = hdu_pkg::HDU_RX_BITS;
                    next_rx_pos = 4'h0;
                    next_rx_phase = 3'h0;
                end
            end
            hdu_pkg::HDU_RX_BITS: begin
                if (tick) begin
                    next_rx_phase = rx_phase + 3'h1;
                    if (rx_phase == hdu_pkg::HDU_SAMPLE_A) begin
                        next_votes[0] = rx_level;
                    end
                    if (rx_phase == hdu_pkg::HDU_SAMPLE_B) begin
                        next_votes[1] = rx_level;
                    end
                    if (rx_phase == hdu_pkg::HDU_SAMPLE_C) begin
                        next_votes[2] = rx_level;
                    end
                    if ((rx_pos == hdu_pkg::HDU_STOP_POS)
                        && (rx_phase == hdu_pkg::HDU_SAMPLE_C)) begin
                        next_rx_buffer = rx_shift[7:0];
                        next_rx_state = hdu_pkg::HDU_RX_HUNT;
                        rx_done = 1'b1;
                    end
                    if (rx_phase == hdu_pkg::HDU_LAST_PHASE) begin
                        next_rx_pos = rx_pos + 4'h1;
                        if (rx_pos == 4'h0) begin
                            // start bit only waited out, no check
                        end else if (rx_pos != hdu_pkg::HDU_STOP_POS) begin
                            next_rx_shift = {vote_bit, rx_shift[8:1]};
                            ninth_load = (rx_pos == hdu_pkg::HDU_NINTH_POS);
                        end
                    end
                end
            end
            default: next_rx_state = hdu_pkg::HDU_RX_HUNT;
        endcase
        // transmit has priority: the partial character is dropped
        if (data_wr) begin
            next_rx_state = hdu_pkg::HDU_RX_HUNT;
            rx_done = 1'b0;
            ninth_load = 1'b0;
            next_rx_buffer = rx_buffer;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            rx_state <= hdu_pkg::HDU_RX_HUNT;
            rx_shift <= 9'h000;
            rx_pos <= 4'h0;
            rx_phase <= 3'h0;
            votes <= 3'h0;
            rx_buffer <= hdu_pkg::HDU_DATA_RESET;
        end else begin
            rx_state <= next_rx_state;
            rx_shift <= next_rx_shift;
            rx_pos <= next_rx_pos;
            rx_phase <= next_rx_phase;
            votes <= next_votes;
            rx_buffer <= next_rx_buffer;
        end
    end

    // control/status: hardware set beats a software clear in the same cycle
    always_comb begin
        next_receiver_ready_flag = receiver_ready_flag;
        next_transmitter_empty_flag = transmitter_empty_flag;
        next_receive_irq_enable = receive_irq_enable;
        next_transmit_irq_enable = transmit_irq_enable;
        next_baud_select = baud_select;
        next_ninth_bit = ninth_bit;
        if (ctrl_wr) begin
            next_receiver_ready_flag = avs_writedata[hdu_pkg::HDU_CR_RECEIVER_READY_FLAG];
            next_transmitter_empty_flag = avs_writedata[hdu_pkg::HDU_CR_TRANSMITTER_EMPTY_FLAG];
            next_receive_irq_enable = avs_writedata[hdu_pkg::HDU_CR_RECEIVE_IRQ_ENABLE];
            next_transmit_irq_enable = avs_writedata[hdu_pkg::HDU_CR_TRANSMIT_IRQ_ENABLE];
            next_baud_select = avs_writedata[hdu_pkg::HDU_CR_BAUD_LSB +: 3];
            next_ninth_bit = avs_writedata[hdu_pkg::HDU_CR_NINTH];
        end
        if (data_wr) begin
            next_transmitter_empty_flag = 1'b0;
        end
        if (tx_done) begin
            next_transmitter_empty_flag = 1'b1;
        end
        if (rx_done) begin
            next_receiver_ready_flag = 1'b1;
        end
        if (ninth_load) begin
            next_ninth_bit = vote_bit;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            receiver_ready_flag <= hdu_pkg::HDU_CTRL_RESET[hdu_pkg::HDU_CR_RECEIVER_READY_FLAG];
            transmitter_empty_flag <= hdu_pkg::HDU_CTRL_RESET[hdu_pkg::HDU_CR_TRANSMITTER_EMPTY_FLAG];
            receive_irq_enable <= hdu_pkg::HDU_CTRL_RESET[hdu_pkg::HDU_CR_RECEIVE_IRQ_ENABLE];
            transmit_irq_enable <= hdu_pkg::HDU_CTRL_RESET[hdu_pkg::HDU_CR_TRANSMIT_IRQ_ENABLE];
            baud_select <= hdu_pkg::HDU_CTRL_RESET[hdu_pkg::HDU_CR_BAUD_LSB +: 3];
            ninth_bit <= hdu_pkg::HDU_CTRL_RESET[hdu_pkg::HDU_CR_NINTH];
        end else begin
            receiver_ready_flag <= next_receiver_ready_flag;
            transmitter_empty_flag <= next_transmitter_empty_flag;
            receive_irq_enable <= next_receive_irq_enable;
            transmit_irq_enable <= next_transmit_irq_enable;
            baud_select <= next_baud_select;
            ninth_bit <= next_ninth_bit;
        end
    end

    // enables only gate the pending flags, a software-set flag interrupts too
    assign uart_irq = (receiver_ready_flag & receive_irq_enable) | (transmitter_empty_flag & transmit_irq_enable);

    // checks
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_tx_start;
        data_wr ##1 transmitter_output_select;
    endsequence

    sequence s_start_on_pin;
        (serial_out_pin == 1'b1) && (tx_shift[0] == 1'b0);
    endsequence

    property p_frame_end;
        (tx_done && tx_pos == 4'ha) |=> !transmitter_output_select;
    endproperty
    a_frame_end: assert property (p_frame_end) else $error("frame not eleven bits");

    property p_abort_rx;
        data_wr |=> (rx_state == hdu_pkg::HDU_RX_HUNT) && !receiver_ready_flag || $past(receiver_ready_flag);
    endproperty
    a_abort_rx: assert property (p_abort_rx) else $error("reception not aborted");

    property p_phase_wrap;
        (rx_state == hdu_pkg::HDU_RX_BITS && tick && rx_phase == 3'h7 && !data_wr)
            |=> rx_phase == 3'h0;
    endproperty
    a_phase_wrap: assert property (p_phase_wrap) else $error("not eight states per bit");

    property p_div_fastest;
        (baud_select == 3'h6 && $past(baud_select) == 3'h6 && tick) |-> $past(presc) == 10'h018;
    endproperty
    a_div_fastest: assert property (p_div_fastest) else $error("division 208 wrong");

    property p_tx_start;
        s_tx_start |=> s_start_on_pin;
    endproperty
    a_tx_start: assert property (p_tx_start) else $error("start bit not sent inverted");

    property p_port_follow;
        (!transmitter_output_select && $past(rst_n)) |=> serial_out_pin == $past(port_out_value);
    endproperty
    a_port_follow: assert property (p_port_follow) else $error("pin not on port value");

    property p_transmitter_empty_flag_set;
        tx_done |=> transmitter_empty_flag ##0 (uart_irq == (transmit_irq_enable || (receiver_ready_flag && receive_irq_enable)));
    endproperty
    a_transmitter_empty_flag_set: assert property (p_transmitter_empty_flag_set) else $error("empty flag not set");

    property p_transmitter_empty_flag_clear;
        (data_wr && !tx_done) |=> !transmitter_empty_flag;
    endproperty
    a_transmitter_empty_flag_clear: assert property (p_transmitter_empty_flag_clear) else $error("empty flag not cleared");

    property p_rx_hunt;
        (rx_state == hdu_pkg::HDU_RX_HUNT && transmitter_output_select)
            |=> rx_state == hdu_pkg::HDU_RX_HUNT;
    endproperty
    a_rx_hunt: assert property (p_rx_hunt) else $error("receiver started while sending");

    property p_ninth;
        ninth_load |=> ninth_bit == $past(vote_bit);
    endproperty
    a_ninth: assert property (p_ninth) else $error("ninth bit not copied");

    property p_buffer;
        rx_done |=> (rx_buffer == $past(rx_shift[7:0])) && receiver_ready_flag;
    endproperty
    a_buffer: assert property (p_buffer) else $error("buffer or ready flag wrong");

    property p_read_buf;
        (avs_read && avs_waitrequest && avs_address == hdu_pkg::HDU_DATA_ADDR)
            |=> avs_readdata == {24'h00_0000, $past(rx_buffer)};
    endproperty
    a_read_buf: assert property (p_read_buf) else $error("data read not buffer");
endmodule

//--- verilog/hdu_pkg.sv
// constants, register map and state types of the half-duplex nine-bit serial port
package hdu_pkg;
    // register indices, byte address is four times the index
    localparam logic [7:0] HDU_DATA_IDX = 8'hd6;
    localparam logic [7:0] HDU_CTRL_IDX = 8'hd7;
    localparam logic [9:0] HDU_DATA_ADDR = {HDU_DATA_IDX, 2'b00};
    localparam logic [9:0] HDU_CTRL_ADDR = {HDU_CTRL_IDX, 2'b00};

    // control/status field positions
    localparam int HDU_CR_RECEIVER_READY_FLAG = 7;
    localparam int HDU_CR_TRANSMITTER_EMPTY_FLAG = 6;
    localparam int HDU_CR_RECEIVE_IRQ_ENABLE = 5;
    localparam int HDU_CR_TRANSMIT_IRQ_ENABLE = 4;
    localparam int HDU_CR_BAUD_LSB = 1;
    localparam int HDU_CR_NINTH = 0;
    localparam logic [7:0] HDU_CTRL_RESET = 8'h00;
    localparam logic [7:0] HDU_DATA_RESET = 8'h00;

    // clock division factors per baud code, code 3'b111 reserved
    localparam logic [13:0] HDU_DIV0 = 14'h1a00;
    localparam logic [13:0] HDU_DIV1 = 14'h0d00;
    localparam logic [13:0] HDU_DIV2 = 14'h0680;
    localparam logic [13:0] HDU_DIV3 = 14'h0340;
    localparam logic [13:0] HDU_DIV4 = 14'h01a0;
    localparam logic [13:0] HDU_DIV5 = 14'h0100;
    localparam logic [13:0] HDU_DIV6 = 14'h00d0;
    localparam logic [2:0] HDU_BAUD_RSVD = 3'h7;
    localparam int HDU_STATE_SHIFT = 3;

    // bit-time phases and frame positions
    localparam logic [2:0] HDU_SAMPLE_A = 3'h3;
    localparam logic [2:0] HDU_SAMPLE_B = 3'h4;
    localparam logic [2:0] HDU_SAMPLE_C = 3'h5;
    localparam logic [2:0] HDU_LAST_PHASE = 3'h7;
    localparam logic [3:0] HDU_NINTH_POS = 4'h9;
    localparam logic [3:0] HDU_STOP_POS = 4'ha;

    typedef enum logic {HDU_TX_IDLE, HDU_TX_SEND} hdu_tx_state_t;
    typedef enum logic {HDU_RX_HUNT, HDU_RX_BITS} hdu_rx_state_t;
endpackage

//--- tb/hdu_remote_station.sv
// remote serial station model: sends frames and captures frames sent to it
`timescale 1ns/10ps
module hdu_remote_station #(
    parameter int BIT_CYCLES = 208
) (
    input wire logic sys_clk,
    input wire logic serial_out_pin,
    input wire logic transmitter_output_select,
    output logic serial_in_pin
);
    logic [10:0] cap;
    logic [8:0] rx_word;
    logic rx_good;
    int rx_count;

    // line idles high, like a pulled-up receive wire
    initial begin
        serial_in_pin = 1'b1;
        rx_word = '0;
        rx_good = 1'b0;
        rx_count = 0;
    end

    // frame marked by select rise: idle and inverted start look alike on the pin
    always @(posedge transmitter_output_select) begin
        repeat (1 + BIT_CYCLES / 2) @(posedge sys_clk);
        for (int k = 0; k < 11; k++) begin
            cap[k] = ~serial_out_pin;
            if (k < 10) begin
                repeat (BIT_CYCLES) @(posedge sys_clk);
            end
        end
        rx_word = cap[9:1];
        rx_good = (cap[0] == 1'b0) && (cap[10] == 1'b1);
        rx_count++;
    end

    // start zero, nine bits lsb first, stop one, then idle high
    task automatic send_frame(input logic [8:0] word);
        logic [10:0] f;
        f = {1'b1, word, 1'b0};
        for (int k = 0; k < 11; k++) begin
            @(posedge sys_clk);
            serial_in_pin <= f[k];
            repeat (BIT_CYCLES - 1) @(posedge sys_clk);
        end
    endtask
endmodule

//--- tb/tb_top.sv
// self-checking bench for the half-duplex nine-bit serial port
`timescale 1ns/10ps
module tb_top;
    localparam logic [9:0] DA = hdu_pkg::HDU_DATA_ADDR;
    localparam logic [9:0] CA = hdu_pkg::HDU_CTRL_ADDR;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [9:0] avs_address = '0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [3:0] avs_byteenable = 4'hf;
    logic [31:0] avs_writedata = '0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic serial_in_pin;
    logic port_out_value = 1'b1;
    logic serial_out_pin;
    logic transmitter_output_select;
    logic uart_irq;
    int mismatches = 0;
    int check_count = 0;
    int divs [8] = '{6656, 3328, 1664, 832, 416, 256, 208, 8000};

    // 40 MHz clock
    always #12.5 sys_clk = ~sys_clk;

    hdu_uart u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(avs_byteenable),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .serial_in_pin(serial_in_pin),
        .port_out_value(port_out_value), .serial_out_pin(serial_out_pin),
        .transmitter_output_select(transmitter_output_select), .uart_irq(uart_irq));

    hdu_remote_station #(.BIT_CYCLES(208)) u_remote (.sys_clk(sys_clk),
        .serial_out_pin(serial_out_pin), .transmitter_output_select(transmitter_output_select),
        .serial_in_pin(serial_in_pin));

    task automatic conclude;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask

    // one avalon transfer, held until waitrequest is seen low at an edge
    task automatic bus(input logic wr, input logic [9:0] a, input logic [7:0] d,
                       output logic [31:0] q);
        int n;
        n = 0;
        @(posedge sys_clk);
        avs_address <= a;
        avs_writedata <= {24'h00_0000, d};
        avs_write <= wr;
        avs_read <= ~wr;
        do begin
            @(posedge sys_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        chk(32'(n < 50), 32'h0000_0001, "bus answer");
    endtask

    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rdchk(input logic [9:0] a, input logic [7:0] e, input string msg);
        logic [31:0] q;
        bus(1'b0, a, 8'h00, q);
        chk(q, {24'h00_0000, e}, msg);
    endtask

    // poll control until a flag shows; bounded so a dead flag cannot hang
    task automatic wait_ctrl(input logic [7:0] m);
        logic [31:0] q;
        int n;
        n = 0;
        q = '0;
        while ((q[7:0] & m) == 8'h00 && n < 4000) begin
            bus(1'b0, CA, 8'h00, q);
            n++;
        end
        chk(32'(q[7:0] & m), 32'(m), "flag wait");
    endtask

    // watchdog sized well above the expected run of about 55k cycles
    initial begin
        repeat (100000) @(posedge sys_clk);
        mismatches++;
        conclude();
    end

    initial begin
        int n;
        int w;
        int base;
        repeat (6) @(posedge sys_clk);
        rst_n <= 1'b1;
        rdchk(CA, hdu_pkg::HDU_CTRL_RESET, "ctrl reset");
        rdchk(DA, hdu_pkg::HDU_DATA_RESET, "data reset");
        chk(32'({transmitter_output_select, uart_irq}), 32'h0000_0000, "idle outs");
        wr(10'h000, 8'hff);
        rdchk(10'h000, 8'h00, "unmapped read");
        avs_byteenable <= 4'h0;
        wr(CA, 8'hff);
        avs_byteenable <= 4'hf;
        rdchk(CA, 8'h00, "lane off write");
        $display("test reset and map done");

        // start-bit width per baud code; code 7 must stall
        for (int c = 0; c < 8; c++) begin
            wr(CA, {4'h0, 3'(c), 1'b0});
            wr(DA, 8'h01);
            n = 0;
            while (serial_out_pin !== 1'b1 && n < 50) begin
                @(posedge sys_clk);
                n++;
            end
            w = 0;
            while (serial_out_pin === 1'b1 && w < 8000) begin
                @(posedge sys_clk);
                w++;
            end
            chk(32'(w >= divs[c] - 2 && w <= divs[c] + 2), 32'h0000_0001, "bit time");
            wr(CA, 8'h0c);
            wr(DA, 8'h01);
            wait_ctrl(8'h40);
        end
        $display("test baud table done");

        wr(CA, 8'h1d);
        base = u_remote.rx_count;
        wr(DA, 8'ha5);
        repeat (2) @(posedge sys_clk);
        chk(32'({transmitter_output_select, uart_irq}), 32'h0000_0002, "sending");
        wait_ctrl(8'h40);
        chk(32'({transmitter_output_select, uart_irq}), 32'h0000_0001, "sent");
        chk(32'(u_remote.rx_count - base), 32'h0000_0001, "frame count");
        chk(32'({u_remote.rx_good, u_remote.rx_word}), 32'h0000_03a5, "frame");
        port_out_value <= 1'b0;
        repeat (3) @(posedge sys_clk);
        chk(32'(serial_out_pin), 32'h0000_0000, "port follow");
        port_out_value <= 1'b1;
        rdchk(CA, 8'h5d, "ninth kept");
        wr(CA, 8'h4d);
        @(posedge sys_clk);
        chk(32'(uart_irq), 32'h0000_0000, "tx irq gated");
        rdchk(CA, 8'h4d, "flag kept");
        wr(CA, 8'h1d);
        rdchk(CA, 8'h1d, "transmitter_empty_flag zero write");
        wr(CA, 8'h5d);
        @(posedge sys_clk);
        chk(32'(uart_irq), 32'h0000_0001, "soft irq");
        wr(DA, 8'h3c);
        rdchk(CA, 8'h1d, "transmitter_empty_flag data clear");
        wait_ctrl(8'h40);
        chk(32'(u_remote.rx_word), 32'h0000_013c, "second frame");
        $display("test transmit done");

        wr(CA, 8'h2d);
        u_remote.send_frame(9'h096);
        wait_ctrl(8'h80);
        rdchk(DA, 8'h96, "rx data");
        rdchk(CA, 8'hac, "rx ninth");
        chk(32'(uart_irq), 32'h0000_0001, "rx irq");
        wr(CA, 8'h2c);
        @(posedge sys_clk);
        chk(32'(uart_irq), 32'h0000_0000, "rx clear");
        u_remote.send_frame(9'h1e1);
        u_remote.send_frame(9'h02a);
        wait_ctrl(8'h80);
        rdchk(DA, 8'h2a, "back to back");
        rdchk(CA, 8'hac, "ninth again");
        wr(CA, 8'h8c);
        @(posedge sys_clk);
        chk(32'(uart_irq), 32'h0000_0000, "rx irq gated");
        rdchk(CA, 8'h8c, "receiver_ready_flag soft set");
        $display("test receive done");

        // transmit started three bits into a reception
        wr(CA, 8'h0d);
        fork
            u_remote.send_frame(9'h055);
            begin
                repeat (624) @(posedge sys_clk);
                wr(DA, 8'h81);
            end
        join
        wait_ctrl(8'h40);
        rdchk(CA, 8'h4d, "rx aborted");
        chk(32'(u_remote.rx_word), 32'h0000_0181, "tx wins");
        $display("test abort done");
        conclude();
    end
endmodule
